// file: verilog/exposure_timer_map.vh
// Constants for the exposure timer and turn-off block
`ifndef EXPOSURE_TIMER_MAP_VH
`define EXPOSURE_TIMER_MAP_VH
`define CLK_FREQ_HZ 100000000
`define TICK_PERIOD_S 1
`define TICK_CYCLES (`CLK_FREQ_HZ * `TICK_PERIOD_S)
`define DEBOUNCE_MS 10
`define DEBOUNCE_CYCLES (`CLK_FREQ_HZ / 1000 * `DEBOUNCE_MS)
`define DIGITS 4
`define COUNT_W 16
`define COUNT_RESET 16'h0000
`define BCD_MAX 4'h9
`define ST_IDLE 2'h0
`define ST_RUN 2'h1
`define ST_HOLD 2'h2
`endif

// file: verilog/exposure_timer_turnoff.v
// Exposure counter, seconds tick, exposure latch and turn-off stage
`timescale 1ns/1ps
`default_nettype none
`include "exposure_timer_map.vh"
module exposure_timer_turnoff #(
    parameter [31:0] TICK_CYCLES = `TICK_CYCLES,
    parameter [31:0] DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES
) (
    input wire clk,
    input wire rstn,
    input wire start_switch,
    input wire sensor_reset_switch,
    input wire auto_manual_selector,
    input wire [15:0] time_set_switches,
    input wire tube_current_over_ref,
    input wire sensor_over_ref,
    output wire interlock_turnoff_relay,
    output wire timer_input_indicator,
    output wire overcurrent_input_indicator,
    output wire auto_input_indicator,
    output reg [15:0] display_value,
    output reg display_on,
    output wire count_up,
    output wire store_hold_n,
    output wire tick_enable,
    output reg seconds_tick,
    output wire exposure_latch,
    output wire exposure_latch_n,
    output reg counter_carry
);

////////////////////////////////////////////////////////////////////////////////
// Reset synchronizer
reg rst_s1;
reg rst_s2;
always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        rst_s1 <= 1'b0;
        rst_s2 <= 1'b0;
    end else begin
        rst_s1 <= 1'b1;
        rst_s2 <= rst_s1;
    end
end
wire srst_n = rst_s2;

////////////////////////////////////////////////////////////////////////////////
// Switch debouncers
wire [2:0] sw_raw = {auto_manual_selector, sensor_reset_switch, start_switch};
wire [2:0] sw_clean;
wire [31:0] debounce_last = DEBOUNCE_CYCLES - 32'h00000001;
genvar gi;

generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_deb
        reg s1;
        reg s2;
        reg stable;
        reg [31:0] cnt;

        wire differs = (s2 != stable);
        wire settled = (cnt >= debounce_last);

        always @(posedge clk or negedge srst_n) begin
            if (!srst_n) begin
                s1 <= 1'b0;
                s2 <= 1'b0;
            end else begin
                s1 <= sw_raw[gi];
                s2 <= s1;
            end
        end

        always @(posedge clk or negedge srst_n) begin
            if (!srst_n) begin
                stable <= 1'b0;
                cnt <= 32'h00000000;
            end else if (!differs) begin
                cnt <= 32'h00000000;
            end else if (settled) begin
                stable <= s2;
                cnt <= 32'h00000000;
            end else begin
                cnt <= cnt + 32'h00000001;
            end
        end

        assign sw_clean[gi] = stable;
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Switch levels and edges
wire start_lvl = sw_clean[0];
wire sensor_reset = sw_clean[1];
wire auto_mode = sw_clean[2];

reg start_prev;
reg auto_prev;

always @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
        start_prev <= 1'b0;
    end else begin
        start_prev <= start_lvl;
    end
end

always @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
        auto_prev <= 1'b0;
    end else begin
        auto_prev <= auto_mode;
    end
end

wire start_edge = start_lvl & ~start_prev;
wire to_manual = auto_prev & ~auto_mode;

////////////////////////////////////////////////////////////////////////////////
// Turn-off inputs
wire overcurrent_trip_comparator = tube_current_over_ref;
wire auto_path_gate = auto_mode;
wire auto_exposure_control = auto_path_gate & sensor_over_ref;

reg latch_q;
wire time_off = latch_q;

////////////////////////////////////////////////////////////////////////////////
// Turn-off stage and indicators
wire turn_off_or_stage = time_off | overcurrent_trip_comparator | auto_exposure_control;
assign interlock_turnoff_relay = ~turn_off_or_stage;
assign timer_input_indicator = ~time_off;
assign overcurrent_input_indicator = ~overcurrent_trip_comparator;
assign auto_input_indicator = ~auto_exposure_control;

////////////////////////////////////////////////////////////////////////////////
// Control state
reg [1:0] state;
reg [1:0] next_state;
reg [15:0] count;

wire running = (state == `ST_RUN);
wire holding = (state == `ST_HOLD);
wire idle = (state == `ST_IDLE);

wire count_zero = (count == `COUNT_RESET);
wire forced_off = overcurrent_trip_comparator | auto_exposure_control;
wire end_exposure = running & (counter_carry | forced_off);

always @* begin
    next_state = state;
    case (state)
        `ST_IDLE: begin
            if (start_edge) begin
                next_state = `ST_RUN;
            end
        end
        `ST_RUN: begin
            if (end_exposure && auto_mode) begin
                next_state = `ST_HOLD;
            end else if (end_exposure) begin
                next_state = `ST_IDLE;
            end
        end
        `ST_HOLD: begin
            if (start_edge) begin
                next_state = `ST_RUN;
            end else if (to_manual) begin
                next_state = `ST_IDLE;
            end
        end
        default: begin
            next_state = `ST_IDLE;
        end
    endcase
end

always @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
        state <= `ST_IDLE;
    end else begin
        state <= next_state;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Mode and exposure outputs
assign exposure_latch = latch_q;
assign exposure_latch_n = ~latch_q;
assign store_hold_n = ~running;
assign tick_enable = running;
assign count_up = auto_mode;

////////////////////////////////////////////////////////////////////////////////
// Exposure latch
wire latch_set = start_edge & ~running;
wire latch_clear = end_exposure;

always @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
        latch_q <= 1'b1;
    end else if (latch_set) begin
        latch_q <= 1'b0;
    end else if (latch_clear) begin
        latch_q <= 1'b1;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Seconds tick source
reg [31:0] prescale;

wire [31:0] tick_last = TICK_CYCLES - 32'h00000001;
wire prescale_done = (prescale >= tick_last);
wire seconds_tick_source = running & prescale_done;

always @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
        prescale <= 32'h00000000;
    end else if (!running || seconds_tick_source) begin
        prescale <= 32'h00000000;
    end else begin
        prescale <= prescale + 32'h00000001;
    end
end

always @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
        seconds_tick <= 1'b0;
    end else begin
        seconds_tick <= seconds_tick_source;
    end
end

////////////////////////////////////////////////////////////////////////////////
// BCD digit steps
wire [`DIGITS-1:0] carry_up;
wire [`DIGITS-1:0] carry_dn;
wire [15:0] next_up;
wire [15:0] next_down;

assign carry_up[0] = 1'b1;
assign carry_dn[0] = 1'b1;
genvar dg;

generate
    for (dg = 0; dg < `DIGITS; dg = dg + 1) begin : g_digit
        wire [3:0] digit;
        wire at_max;
        wire at_zero;

        assign digit = count[dg*4 +: 4];
        assign at_max = (digit == `BCD_MAX);
        assign at_zero = (digit == 4'h0);

        assign next_up[dg*4 +: 4] = !carry_up[dg] ? digit
            : (at_max ? 4'h0 : digit + 4'h1);
        assign next_down[dg*4 +: 4] = !carry_dn[dg] ? digit
            : (at_zero ? `BCD_MAX : digit - 4'h1);

        if (dg < `DIGITS - 1) begin : g_chain
            assign carry_up[dg + 1] = carry_up[dg] & at_max;
            assign carry_dn[dg + 1] = carry_dn[dg] & at_zero;
        end
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Exposure counter driver
wire exposure_counter_driver = running & seconds_tick_source;
wire load_start = start_edge & ~running;
wire load_preset = ~running & latch_q & ~auto_mode & ~holding;
wire clear_count = sensor_reset & ~running;

always @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
        count <= `COUNT_RESET;
    end else if (load_start && auto_mode) begin
        count <= `COUNT_RESET;
    end else if (load_start) begin
        count <= time_set_switches;
    end else if (load_preset) begin
        count <= time_set_switches;
    end else if (clear_count) begin
        count <= `COUNT_RESET;
    end else if (exposure_counter_driver && auto_mode) begin
        count <= next_up;
    end else if (exposure_counter_driver) begin
        count <= next_down;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Zero carry pulse
wire manual_run = running & ~auto_mode;

always @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
        counter_carry <= 1'b0;
    end else if (load_start || load_preset || clear_count) begin
        counter_carry <= 1'b0;
    end else if (exposure_counter_driver && !auto_mode) begin
        counter_carry <= (next_down == `COUNT_RESET);
    end else if (manual_run && count_zero && !counter_carry) begin
        counter_carry <= 1'b1;
    end else begin
        counter_carry <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Display value
always @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
        display_value <= `COUNT_RESET;
    end else if (load_start && auto_mode) begin
        display_value <= `COUNT_RESET;
    end else if (load_start) begin
        display_value <= time_set_switches;
    end else if (running) begin
        display_value <= count;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Display blanking
always @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
        display_on <= 1'b0;
    end else if (load_start) begin
        display_on <= 1'b1;
    end else if (running && end_exposure && !auto_mode) begin
        display_on <= 1'b0;
    end else if (holding && to_manual) begin
        display_on <= 1'b0;
    end else if (idle && !auto_mode) begin
        display_on <= 1'b0;
    end
end

endmodule // exposure_timer_turnoff
`default_nettype wire

// file: test/panel_model.sv
// Operator panel and analog comparator model
`timescale 1ns/1ps
`default_nettype none
module panel_model (
    input wire logic clk,
    input wire logic [7:0] tube_level,
    input wire logic [7:0] sensor_level,
    input wire logic press,
    output logic tube_current_over_ref,
    output logic sensor_over_ref,
    output logic start_switch
);
    localparam logic [7:0] REF = 8'h80;
    initial begin
        tube_current_over_ref = 1'b0;
        sensor_over_ref = 1'b0;
        start_switch = 1'b0;
    end
    always @(posedge clk) begin
        tube_current_over_ref <= tube_level > REF;
        sensor_over_ref <= sensor_level > REF;
        start_switch <= press;
    end
endmodule // panel_model
`default_nettype wire

// file: test/exposure_timer_chk.sv
// Assertion checker for the exposure timer block
`timescale 1ns/1ps
`default_nettype none
module exposure_timer_chk #(parameter [31:0] TICK_CYCLES = 10) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic tube_current_over_ref,
    input wire logic [15:0] time_set_switches,
    input wire logic interlock_turnoff_relay,
    input wire logic timer_input_indicator,
    input wire logic overcurrent_input_indicator,
    input wire logic auto_input_indicator,
    input wire logic [15:0] display_value,
    input wire logic display_on,
    input wire logic count_up,
    input wire logic store_hold_n,
    input wire logic tick_enable,
    input wire logic seconds_tick,
    input wire logic exposure_latch,
    input wire logic exposure_latch_n,
    input wire logic counter_carry
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    logic [31:0] gap;
    logic gap_ok;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            gap <= 32'h0;
            gap_ok <= 1'b0;
        end else begin
            gap <= seconds_tick ? 32'h1 : gap + 32'h1;
            gap_ok <= seconds_tick ? 1'b1 : gap_ok & tick_enable;
        end
    end
    AST_TRIP_OPENS: assert property (tube_current_over_ref |-> !interlock_turnoff_relay)
        else $error("relay closed during overcurrent");
    AST_RELAY_RUN: assert property (interlock_turnoff_relay |-> !exposure_latch)
        else $error("relay closed while timed off");
    AST_TIMER_IND: assert property (timer_input_indicator == !exposure_latch)
        else $error("timer indicator wrong");
    AST_LATCH_PAIR: assert property (exposure_latch_n == !exposure_latch)
        else $error("latch outputs not complementary");
    AST_HOLD_LOW: assert property (!store_hold_n == tick_enable)
        else $error("store hold out of step");
    AST_TICK_EN: assert property (seconds_tick |-> $past(tick_enable))
        else $error("tick while disabled");
    AST_START_SHOW: assert property ($fell(exposure_latch) |-> display_on &&
        display_value == (count_up ? 16'h0000 : time_set_switches)) else $error("bad start value");
    AST_CARRY_END: assert property (counter_carry |-> ##[0:1] (exposure_latch && !display_on))
        else $error("carry did not end exposure");
    AST_MANUAL_GATE: assert property (!count_up |-> auto_input_indicator)
        else $error("auto input active in manual");
    AST_TICK_GAP: assert property (seconds_tick && gap_ok |-> gap == TICK_CYCLES)
        else $error("tick spacing wrong");
endmodule // exposure_timer_chk
bind exposure_timer_turnoff exposure_timer_chk #(.TICK_CYCLES(TICK_CYCLES)) chk_u (.*);
`default_nettype wire

// file: test/exposure_timer_turnoff_test.sv
// Self-checking bench for the exposure timer block
`timescale 1ns/1ps
`default_nettype none
module exposure_timer_turnoff_test;
    logic clk = 1'b0, rstn = 1'b0, press = 1'b0, srst = 1'b0, mode = 1'b0;
    logic [15:0] tset = 16'h0000;
    logic [7:0] tube = 8'h00, sens = 8'h00;
    wire start_sw, tube_hi, sens_hi, relay, ind_t, ind_o, ind_a, cup, shn, ten, tick;
    wire lat, lat_n, carry, d_on;
    wire [15:0] dval;
    int fails = 0, checked = 0, nt, i;
    initial forever #5 clk = ~clk;
    panel_model panel_u (.clk(clk), .tube_level(tube), .sensor_level(sens), .press(press),
        .tube_current_over_ref(tube_hi), .sensor_over_ref(sens_hi), .start_switch(start_sw));
    exposure_timer_turnoff #(.TICK_CYCLES(10), .DEBOUNCE_CYCLES(2)) dut_u (.clk(clk),
        .rstn(rstn), .start_switch(start_sw), .sensor_reset_switch(srst),
        .auto_manual_selector(mode), .time_set_switches(tset), .tube_current_over_ref(tube_hi),
        .sensor_over_ref(sens_hi), .interlock_turnoff_relay(relay), .timer_input_indicator(ind_t),
        .overcurrent_input_indicator(ind_o), .auto_input_indicator(ind_a), .display_value(dval),
        .display_on(d_on), .count_up(cup), .store_hold_n(shn), .tick_enable(ten),
        .seconds_tick(tick), .exposure_latch(lat), .exposure_latch_n(lat_n), .counter_carry(carry));
    ////////////////////////////////////////////////////////////////
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task wlat(input logic v);
        for (i = 0; i < 400 && lat !== v; i++) @(negedge clk);
        chk(16'(lat), 16'(v));
    endtask
    task start;
        cyc(1);
        press <= 1'b1;
        cyc(8);
        press <= 1'b0;
        wlat(1'b0);
    endtask
    task give_verdict;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    task t_manual;
        tset <= 16'h0010;
        start;
        chk(dval, 16'h0010);
        chk(16'({d_on, relay, ind_t, shn, ten}), 16'h001D);
        for (i = 0; i < 30 && dval === 16'h0010; i++) @(negedge clk);
        chk(dval, 16'h0009);
        wlat(1'b1);
        chk(16'({d_on, relay, ind_t}), 16'h0000);
    endtask
    task t_trip;
        tset <= 16'h9999;
        start;
        cyc(1);
        tube <= 8'hC0;
        cyc(3);
        @(negedge clk);
        chk(16'({relay, ind_o, lat}), 16'h0001);
        cyc(1);
        tube <= 8'h00;
    endtask
    task t_sensor_manual;
        tset <= 16'h0003;
        sens <= 8'hFF;
        start;
        cyc(5);
        @(negedge clk);
        chk(16'({relay, ind_a}), 16'h0003);
        wlat(1'b1);
        cyc(1);
        sens <= 8'h00;
    endtask
    task t_auto;
        mode <= 1'b1;
        cyc(10);
        start;
        chk(dval, 16'h0000);
        chk(16'(cup), 16'h0001);
        nt = 0;
        for (i = 0; i < 100 && nt < 3; i++) @(negedge clk) nt += int'(tick);
        cyc(3);
        sens <= 8'hFF;
        wlat(1'b1);
        cyc(2);
        @(negedge clk);
        chk(16'({relay, d_on, ind_a}), 16'h0002);
        chk(dval, 16'h0003);
        srst <= 1'b1;
        cyc(8);
        srst <= 1'b0;
        cyc(8);
        chk(dval, 16'h0003);
        sens <= 8'h00;
        mode <= 1'b0;
        cyc(10);
        @(negedge clk);
        chk(16'(d_on), 16'h0000);
        chk(16'(cup), 16'h0000);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        cyc(20);
        rstn <= 1'b1;
        cyc(4);
        @(negedge clk);
        chk(16'({lat, lat_n, relay, d_on}), 16'h0008);
        t_manual;
        t_trip;
        t_sensor_manual;
        t_auto;
        give_verdict;
    end
    initial begin
        #100000;
        fails++;
        give_verdict;
    end
endmodule // exposure_timer_turnoff_test
`default_nettype wire
